// ===== rtl/bwio_defines.vh
`ifndef BWIO_DEFINES_VH
`define BWIO_DEFINES_VH

// ---------------------------------------------------------------
// Register map (byte addresses, one word each)
// ---------------------------------------------------------------
`define BWIO_DATA_OFFSET   8'h00
`define BWIO_DIR_OFFSET    8'h04
`define BWIO_PULL_OFFSET   8'h08

// ---------------------------------------------------------------
// Reset values, and the value the direction offset reads back
// ---------------------------------------------------------------
`define BWIO_DIR_RESET     8'h00
`define BWIO_LATCH_RESET   8'h00
`define BWIO_PULL_RESET    8'h00
`define BWIO_DIR_READ_VAL  8'h00

`endif

// ===== rtl/bwio_port.v
`timescale 1ns/100ps
`include "bwio_defines.vh"

// ---------------------------------------------------------------
// Per-pin cell
// ---------------------------------------------------------------
// One pin's read select and drive decisions, kept in one place
// so that all eight bits follow the same direction rule
module bwio_pin_cell
(
    // Stored settings of this pin
    input  wire dir_bit,
    input  wire latch_bit,
    input  wire pull_bit,
    // Synchronised pin level
    input  wire pin_bit,
    // Decisions handed back to the port
    output wire rd_bit,
    output wire oe_n_bit,
    output wire pull_on_bit
);

    // Output pins read back their latch, input pins the pin level
    assign rd_bit      = dir_bit ? latch_bit : pin_bit;
    // Driven only in output mode; a low enable means driving
    assign oe_n_bit    = ~dir_bit;
    // Pull-up only for an input whose control bit is set
    assign pull_on_bit = pull_bit & ~dir_bit;

endmodule // bwio_pin_cell

module bwio_port
#(
    parameter WIDTH = 8
)
(
    // Clock and reset
    input  wire                clk,
    input  wire                sys_rst,
    // Wishbone slave
    input  wire                wb_cyc_i,
    input  wire                wb_stb_i,
    input  wire                wb_we_i,
    input  wire [7:0]          wb_adr_i,
    input  wire [3:0]          wb_sel_i,
    input  wire [31:0]         wb_dat_i,
    output reg  [31:0]         wb_dat_o,
    output reg                 wb_ack_o,
    output reg                 wb_err_o,
    // Port pins
    input  wire [WIDTH-1:0]    pin_i,
    output reg  [WIDTH-1:0]    pin_o,
    output reg  [WIDTH-1:0]    pin_oe_n,
    output reg  [WIDTH-1:0]    pullup_en
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    reg [WIDTH-1:0] dir_reg;
    reg [WIDTH-1:0] latch_reg;
    reg [WIDTH-1:0] pull_reg;
    reg [WIDTH-1:0] pin_meta_reg;
    reg [WIDTH-1:0] pin_sync_reg;
    reg [WIDTH-1:0] rd_next;
    reg             hit_next;
    // Per-pin decisions from the cell array
    wire [WIDTH-1:0] rd_cell;
    wire [WIDTH-1:0] oe_n_cell;
    wire [WIDTH-1:0] pull_cell;

    wire req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire wr_lane = wb_we_i & wb_sel_i[0];
    wire is_data = (wb_adr_i == `BWIO_DATA_OFFSET);
    wire is_dir  = (wb_adr_i == `BWIO_DIR_OFFSET);
    wire is_pull = (wb_adr_i == `BWIO_PULL_OFFSET);

    // ---------------------------------------------------------------
    // Pin synchroniser
    // ---------------------------------------------------------------
    // Two stages; only the second is looked at by the read path
    // Pin reads therefore trail the pin by two to three clocks,
    // traded for freedom from metastable values on the bus
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            pin_meta_reg <= {WIDTH{1'b0}};
            pin_sync_reg <= {WIDTH{1'b0}};
        end
        else
        begin
            pin_meta_reg <= pin_i;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // Per-pin cells
    // ---------------------------------------------------------------
    // One cell per pin; each bit follows its own direction bit
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_pin
            bwio_pin_cell i_bwio_pin_cell
            (
                .dir_bit     (dir_reg[g]),
                .latch_bit   (latch_reg[g]),
                .pull_bit    (pull_reg[g]),
                .pin_bit     (pin_sync_reg[g]),
                .rd_bit      (rd_cell[g]),
                .oe_n_bit    (oe_n_cell[g]),
                .pull_on_bit (pull_cell[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // Read data and decode
    // ---------------------------------------------------------------
    // Per bit mux: output pins show latch, input pins show pin level
    always @*
    begin
        rd_next  = {WIDTH{1'b0}};
        hit_next = is_data | is_dir | is_pull;
        if (is_data)
            rd_next = rd_cell;
        else if (is_dir)
            rd_next = `BWIO_DIR_READ_VAL;
        else if (is_pull)
            rd_next = pull_reg;
    end

    // ---------------------------------------------------------------
    // Write strobes
    // ---------------------------------------------------------------
    // A store needs lane 0; the other lanes hold nothing of ours
    wire wr_data = req & wr_lane & is_data;
    wire wr_dir  = req & wr_lane & is_dir;
    wire wr_pull = req & wr_lane & is_pull;
    // Reads are answered with data only for mapped offsets
    wire rd_hit  = req & hit_next & ~wb_we_i;

    // ---------------------------------------------------------------
    // Registers and bus answer
    // ---------------------------------------------------------------
    // One wait-free cycle: ack the edge after the request is seen
    // A request is ignored while ack or err stands, so a master
    // that holds stb one cycle too long cannot store twice
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            dir_reg   <= `BWIO_DIR_RESET;
            latch_reg <= `BWIO_LATCH_RESET;
            pull_reg  <= `BWIO_PULL_RESET;
            wb_ack_o  <= 1'b0;
            wb_err_o  <= 1'b0;
            wb_dat_o  <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= req & hit_next;
            wb_err_o <= req & ~hit_next;
            wb_dat_o <= 32'h00000000;
            if (rd_hit)
                wb_dat_o <= {{(32-WIDTH){1'b0}}, rd_next};
            // Whole byte stored regardless of direction; no bit is protected
            if (wr_data)
                latch_reg <= wb_dat_i[WIDTH-1:0];
            // Write-only; software must keep its own copy
            if (wr_dir)
                dir_reg <= wb_dat_i[WIDTH-1:0];
            if (wr_pull)
                pull_reg <= wb_dat_i[WIDTH-1:0];
        end
    end

    // ---------------------------------------------------------------
    // Pin drivers
    // ---------------------------------------------------------------
    // Registered so outputs lag the latch by one cycle
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            pin_o     <= {WIDTH{1'b0}};
            pin_oe_n  <= {WIDTH{1'b1}};
            pullup_en <= {WIDTH{1'b0}};
        end
        else
        begin
            pin_o     <= latch_reg;
            pin_oe_n  <= oe_n_cell;
            pullup_en <= pull_cell;
        end
    end

endmodule // bwio_port

// ===== verification/bwio_props.sv
`timescale 1ns/100ps
// ------------
// Port checker
// ------------
module bwio_props #(parameter WIDTH = 8) (
    // Bus side
    input wire clk, sys_rst, wb_we_i, wb_ack_o,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i, wb_dat_o,
    // Pin side
    input wire [WIDTH-1:0] pin_o, pin_oe_n, pullup_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Acked cycles; master holds data through the ack edge
    wire wr = wb_ack_o & wb_we_i & wb_sel_i[0];
    wire rd = wb_ack_o & !wb_we_i;
    property p_dir; wr && wb_adr_i == 8'h04 |=> pin_oe_n == ~$past(wb_dat_i[7:0]); endproperty
    a_dir: assert property (p_dir) else $error("direction");
    property p_dat; wr && wb_adr_i == 8'h00 |=> pin_o == $past(wb_dat_i[7:0]); endproperty
    a_dat: assert property (p_dat) else $error("latch");
    property p_hiz; wr && wb_adr_i == 8'h00 |=> $stable(pin_oe_n); endproperty
    a_hiz: assert property (p_hiz) else $error("enable");
    property p_pul; wr && wb_adr_i == 8'h08 |=> pullup_en == ($past(wb_dat_i[7:0]) & pin_oe_n); endproperty
    a_pul: assert property (p_pul) else $error("pullup");
    property p_pex; (pullup_en & ~pin_oe_n) == 0; endproperty
    a_pex: assert property (p_pex) else $error("pullup out");
    property p_out; rd && wb_adr_i == 8'h00 |-> ((wb_dat_o[7:0] ^ pin_o) & ~pin_oe_n) == 0; endproperty
    a_out: assert property (p_out) else $error("read out");
    property p_drd; rd && wb_adr_i == 8'h04 |-> wb_dat_o == 0; endproperty
    a_drd: assert property (p_drd) else $error("dir read");
    property p_rst; disable iff (1'b0) sys_rst |=> &pin_oe_n && pullup_en == 0; endproperty
    a_rst: assert property (p_rst) else $error("reset");
endmodule // bwio_props
bind bwio_port bwio_props #(.WIDTH(WIDTH)) i_bwio_props (.clk(clk), .sys_rst(sys_rst),
    .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en));

// ===== verification/bwio_board.sv
`timescale 1ns/100ps
// Board: driven pins show the latch, released ones the outside level
module bwio_board (
    input wire [7:0] ext, pin_o, pin_oe_n,
    output wire [7:0] pin_lvl
);
    assign pin_lvl = (pin_o & ~pin_oe_n) | (ext & pin_oe_n);
endmodule // bwio_board

// ===== verification/bitwise_io_port_with_pullups_tb_top.sv
`timescale 1ns/100ps
module bitwise_io_port_with_pullups_tb_top;
    reg clk = 0, sys_rst = 1, cyc = 0, we = 0, f;
    reg [7:0] adr = 0, ext = 0, d, dir, v;
    reg [31:0] wdat = 0, r;
    wire [31:0] dat_o;
    wire ack, err;
    wire [7:0] po, oe_n, pu, lvl;
    integer error_cnt = 0, n_tests = 0, i;
    bwio_port i_bwio_port (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(err), .pin_i(lvl), .pin_o(po), .pin_oe_n(oe_n), .pullup_en(pu));
    bwio_board i_bwio_board (.ext(ext), .pin_o(po), .pin_oe_n(oe_n), .pin_lvl(lvl));
    initial forever #50 clk = ~clk;
    task stop_test;
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input [31:0] s, input [31:0] e);
        n_tests = n_tests + 1;
        if (s !== e)
        begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask
    // Expected data read: latch for outputs, outside level for inputs
    function [7:0] exp_rd(input [7:0] lat, input [7:0] dr, input [7:0] lv);
        exp_rd = (lat & dr) | (lv & ~dr);
    endfunction
    // One classic cycle; answer looked at between edges, bounded wait
    task bus(input [7:0] a, input w, input [7:0] x);
        integer k;
        begin
            @(posedge clk);
            cyc <= 1; we <= w; adr <= a; wdat <= {24'h0, x};
            k = 0;
            @(negedge clk);
            while (!(ack | err) && k < 20)
            begin
                @(negedge clk);
                k = k + 1;
            end
            if (k == 20)
            begin
                error_cnt = error_cnt + 1;
                stop_test;
            end
            r = dat_o;
            f = err;
            @(posedge clk);
            cyc <= 0;
        end
    endtask
    // All-output, all-input, then random direction mixes; read-back and a bit toggle per round
    initial
    begin
        i = $urandom(5);
        repeat (6) @(posedge clk);
        sys_rst <= 0;
        chk(oe_n, 8'hFF);
        for (i = 0; i < 8; i = i + 1)
        begin
            dir = i == 0 ? 8'hFF : i == 1 ? 8'h00 : 8'($urandom);
            d = 8'($urandom); v = 8'($urandom);
            bus(8'h04, 1, dir);
            bus(8'h00, 1, d);
            bus(8'h08, 1, v);
            ext <= 8'($urandom);
            repeat (4) @(posedge clk);
            chk(oe_n, {24'h0, ~dir});
            chk(po, d);
            chk(pu, v & ~dir);
            bus(8'h04, 0, 0);
            chk(r, 0);
            bus(8'h00, 0, 0);
            chk(r, {24'h0, exp_rd(d, dir, ext)});
            v = r[7:0] ^ 8'h01;
            bus(8'h00, 1, v);
            bus(8'h04, 1, 8'hFF);
            repeat (2) @(posedge clk);
            chk(po, v);
        end
        bus(8'h0C, 0, 0);
        chk(f, 1);
        stop_test;
    end
endmodule // bitwise_io_port_with_pullups_tb_top
